// [shared/pdpm_consts.svh]
// constants for the power derating manager: offsets, fields, reset values, timing
// Notes on behaviour
// R1: pin-two thermistor trip: shutdown or derate
// R2: response select 1: hot level two
// R3: thermistor recovery immediate, selectable hysteresis
// R4: secondary thermistor trips power sharing
// R5: secondary path ignores response select settings
// R6: share level or secondary thermistor shares
// R7: first warning: hot level one limit
// R8: second warning: hot level two limit
// R9: hold derating sixteen seconds after warning
// R10: wait one second before supply checks
// R11: supply below one: low1 limit, flag
// R12: supply below two: low2 limit, flag
// R13: resend capabilities on supply derating with contract
// R14: supply below three: shut down
// R15: supply recovered one second: restore normal
// R16: supply flags clear; detection armed on attach
// R17: low share request input triggers sharing
// R18: share level above threshold: sharing active
// R19: sharing uses shared limit and mask
// R20: fixed current rating/voltage, 3A/5A clamp
// R21: programmable current divides by offset voltages
// R22: sharing: 5V kept, 7.5W floor, 1.5A
// R23: peer bus above 11.2V asserts share
// R24: lowest requested rating wins, with mask
// R25: one mask bit per profile column
`ifndef PDPM_CONSTS_SVH
`define PDPM_CONSTS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PDPM_OFS_CTRL      32'h0000_0000
`define PDPM_OFS_LIM_FIRST 32'h0000_0004
`define PDPM_OFS_LIM_LAST  32'h0000_0018
`define PDPM_OFS_DEGL      32'h0000_001C
`define PDPM_OFS_STATUS    32'h0000_0020

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define PDPM_CTL_PIN1_LSB  0
`define PDPM_CTL_PIN2_LSB  2
`define PDPM_CTL_RESP_BIT  4
`define PDPM_CTL_HYST_BIT  5
`define PDPM_CTL_RST       6'h00
`define PDPM_LIM_RST       16'hFF_78
`define PDPM_DEGL_RST      8'h0A

// ---------------------------------------------------------------
// power figures in half-watt units, currents in 10 mA units
// ---------------------------------------------------------------
`define PDPM_PDP_FLOOR     8'h0F
`define PDPM_PDP_LOWCUR    8'h1E
`define PDPM_CUR_FIX_MAX   12'h12C
`define PDPM_CUR_HI_MAX    12'h1F4
`define PDPM_CUR_SCALE     17'h0_01F4

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PDPM_CLK_HZ        200000000
`define PDPM_HOLD_S        16
`define PDPM_START_S       1
`define PDPM_RISE_S        1
`define PDPM_DEGL_UNIT_US  1000

`endif

// [shared/pdpm_pkg.sv]
// types for the power derating manager
`default_nettype none
package pdpm_pkg;
   // supply-level states, gray along wait-normal-low1-low2-off
   typedef enum logic [2:0] {
      SUP_WAIT = 3'b000,
      SUP_NORM = 3'b001,
      SUP_LOW1 = 3'b011,
      SUP_LOW2 = 3'b010,
      SUP_OFF  = 3'b110
   } pdpm_sup_t;

   // general pin one modes
   typedef enum logic [1:0] {
      PIN1_NONE  = 2'b00,
      PIN1_SHARE = 2'b01,
      PIN1_THERM = 2'b10
   } pdpm_pin1_t;

   // general pin two modes
   typedef enum logic [1:0] {
      PIN2_NONE  = 2'b00,
      PIN2_THERM = 2'b01,
      PIN2_SHARE = 2'b10
   } pdpm_pin2_t;
endpackage
`default_nettype wire

// [logic/pdpm_top.sv]
// power derating manager: rating and profile selection behind an ahb-lite slave
`include "pdpm_consts.svh"
`default_nettype none
module pdpm_top
   import pdpm_pkg::*;
#(
   parameter logic [31:0] HOLD_CYC  = 32'(64'(`PDPM_HOLD_S) * `PDPM_CLK_HZ),
   parameter logic [31:0] START_CYC = 32'(64'(`PDPM_START_S) * `PDPM_CLK_HZ),
   parameter logic [31:0] RISE_CYC  = 32'(64'(`PDPM_RISE_S) * `PDPM_CLK_HZ),
   parameter logic [31:0] DEGL_UNIT = 32'(64'(`PDPM_DEGL_UNIT_US) * (`PDPM_CLK_HZ / 1000000))
) (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // ahb-lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // thermistor comparators
   input  wire logic        therm1_below_i,
   input  wire logic        therm1_rec_a_i,
   input  wire logic        therm1_rec_b_i,
   input  wire logic        therm2_below_i,
   input  wire logic        therm2_rec_a_i,
   input  wire logic        therm2_rec_b_i,
   // share inputs and die warnings
   input  wire logic        share_request_input_n_i,
   input  wire logic        share_level_above_i,
   input  wire logic        first_temp_warning_i,
   input  wire logic        second_temp_warning_i,
   // supply comparators and port state
   input  wire logic        supply_below1_i,
   input  wire logic        supply_below2_i,
   input  wire logic        supply_below3_i,
   input  wire logic        supply_above_rise_i,
   input  wire logic        attach_i,
   input  wire logic        contract_i,
   // profile current query
   input  wire logic [3:0]  profile_sel_i,
   output logic      [11:0] profile_current_o,
   // rating outputs
   output logic      [7:0]  power_limit_o,
   output logic      [8:0]  profile_mask_o,
   output logic             low_current_adv_o,
   output logic             shutdown_o,
   output logic             resend_caps_o,
   output logic             supply_low1_flag_o,
   output logic             supply_low2_flag_o
);

   // ---------------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------------
   // profile voltage in 0.1 V; programmable columns use offset figures
   function automatic logic [16:0] volt_dv(input logic [3:0] idx);
      case (idx)
         4'd0:    volt_dv = 17'd50;
         4'd1:    volt_dv = 17'd90;
         4'd2:    volt_dv = 17'd120;
         4'd3:    volt_dv = 17'd150;
         4'd4:    volt_dv = 17'd200;
         4'd5:    volt_dv = 17'd59;  // [R21]
         4'd6:    volt_dv = 17'd110; // [R21]
         4'd7:    volt_dv = 17'd160; // [R21]
         default: volt_dv = 17'd210; // [R21]
      endcase
   endfunction

   // current = rating / voltage, clamped by column class
   function automatic logic [11:0] calc_cur(input logic [7:0] pdp, input logic [3:0] idx);
      logic [16:0] q;
      logic [11:0] cap;
      q   = (17'(pdp) * `PDPM_CUR_SCALE) / volt_dv(idx);
      cap = (idx < 4'd4) ? `PDPM_CUR_FIX_MAX : `PDPM_CUR_HI_MAX; // [R20]
      calc_cur = (q > 17'(cap)) ? cap : q[11:0];
   endfunction

   // keep the lower of two candidates, mask travels with its limit
   function automatic logic [15:0] pick_min(input logic [15:0] cur, input logic on, input logic [15:0] cand);
      pick_min = (on && cand[7:0] < cur[7:0]) ? cand : cur; // [R24]
   endfunction

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [5:0]  ctrl_r;
   logic [15:0] lim_r [0:5]; // normal, share, low1, low2, hot1, hot2
   logic [7:0]  degl_r;
   logic        dph_wr_r;
   logic [31:0] dph_addr_r;
   logic [31:0] hrdata_r;

   wire         ahb_go   = hsel_i && htrans_i[1] && hready_i;
   wire         a_ctrl   = (haddr_i == `PDPM_OFS_CTRL);
   wire         a_lim    = (haddr_i >= `PDPM_OFS_LIM_FIRST) && (haddr_i <= `PDPM_OFS_LIM_LAST)
                           && (haddr_i[1:0] == 2'b00);
   wire         a_degl   = (haddr_i == `PDPM_OFS_DEGL);
   wire         a_stat   = (haddr_i == `PDPM_OFS_STATUS);
   wire [2:0]   a_idx    = 3'((haddr_i - `PDPM_OFS_LIM_FIRST) >> 2);
   wire         w_ctrl   = dph_wr_r && (dph_addr_r == `PDPM_OFS_CTRL);
   wire         w_degl   = dph_wr_r && (dph_addr_r == `PDPM_OFS_DEGL);
   wire         w_lim    = dph_wr_r && (dph_addr_r >= `PDPM_OFS_LIM_FIRST)
                           && (dph_addr_r <= `PDPM_OFS_LIM_LAST) && (dph_addr_r[1:0] == 2'b00);
   wire [2:0]   w_idx    = 3'((dph_addr_r - `PDPM_OFS_LIM_FIRST) >> 2);

   wire pdpm_pin1_t pin1_mode = pdpm_pin1_t'(ctrl_r[`PDPM_CTL_PIN1_LSB +: 2]);
   wire pdpm_pin2_t pin2_mode = pdpm_pin2_t'(ctrl_r[`PDPM_CTL_PIN2_LSB +: 2]);
   wire         resp_sel  = ctrl_r[`PDPM_CTL_RESP_BIT];
   wire         hyst_sel  = ctrl_r[`PDPM_CTL_HYST_BIT];

   logic [31:0] status_w;
   wire  [31:0] rd_nxt;

   // read data is sampled in the address phase so it stands in the data phase
   assign rd_nxt = a_ctrl ? 32'(ctrl_r) :
                   a_lim  ? 32'(lim_r[a_idx]) :
                   a_degl ? 32'(degl_r) :
                   a_stat ? status_w : 32'h0000_0000;

   // bus pipeline; waits only until the first clock after reset, always okay
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dph_wr_r    <= 1'b0;
         dph_addr_r  <= 32'h0000_0000;
         hrdata_r    <= 32'h0000_0000;
         hreadyout_o <= 1'b0;
         hresp_o     <= 1'b0;
      end else begin
         dph_wr_r    <= ahb_go && hwrite_i;
         dph_addr_r  <= haddr_i;
         hrdata_r    <= (ahb_go && !hwrite_i) ? rd_nxt : 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
   end
   assign hrdata_o = hrdata_r;

   // configuration writes land in the data phase
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_r <= `PDPM_CTL_RST;
         degl_r <= `PDPM_DEGL_RST;
         for (int i = 0; i < 6; i++) begin
            lim_r[i] <= `PDPM_LIM_RST;
         end
      end else begin
         if (w_ctrl) ctrl_r <= hwdata_i[5:0];
         if (w_degl) degl_r <= hwdata_i[7:0];
         if (w_lim)  lim_r[w_idx] <= hwdata_i[15:0];
      end
   end

   // ---------------------------------------------------------------
   // thermistor paths
   // ---------------------------------------------------------------
   logic t1_trip_r;
   logic t2_trip_r;
   wire  t1_en  = (pin2_mode == PIN2_THERM);
   wire  t2_en  = (pin1_mode == PIN1_THERM);
   wire  t1_rec = hyst_sel ? therm1_rec_b_i : therm1_rec_a_i;  // [R3]
   wire  t2_rec = hyst_sel ? therm2_rec_b_i : therm2_rec_a_i;  // [R5]
   wire  t1_nxt = t1_en && (therm1_below_i || (t1_trip_r && !t1_rec)); // [R1] [R3]
   wire  t2_nxt = t2_en && (therm2_below_i || (t2_trip_r && !t2_rec)); // [R4]

   // trip holds until the chosen recovery level; no hold timer here
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         t1_trip_r <= 1'b0;
         t2_trip_r <= 1'b0;
      end else begin
         t1_trip_r <= t1_nxt;
         t2_trip_r <= t2_nxt;
      end
   end

   // ---------------------------------------------------------------
   // power sharing triggers
   // ---------------------------------------------------------------
   logic share_act_r;
   // the peer's bus threshold is external; only the level arrives here
   wire  share_trig = ((pin1_mode == PIN1_SHARE) && !share_request_input_n_i) // [R17]
                   || (t2_en && t2_trip_r)                                   // [R4] [R6]
                   || ((pin2_mode == PIN2_SHARE) && share_level_above_i);    // [R18] [R23]

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) share_act_r <= 1'b0;
      else       share_act_r <= share_trig;
   end

   // ---------------------------------------------------------------
   // die temperature level with recovery hold
   // ---------------------------------------------------------------
   logic [1:0]  hot_r;
   logic [31:0] hold_cnt_r;
   wire  [1:0]  hot_now  = second_temp_warning_i ? 2'd2 : first_temp_warning_i ? 2'd1 : 2'd0; // [R7] [R8]
   wire         hold_end = (hold_cnt_r >= HOLD_CYC - 32'd1);
   wire  [1:0]  hot_nxt  = (hot_now >= hot_r || hold_end) ? hot_now : hot_r; // [R9]
   wire  [31:0] hold_nxt = (hot_now >= hot_r || hold_end) ? 32'd0 : hold_cnt_r + 32'd1;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hot_r      <= 2'd0;
         hold_cnt_r <= 32'd0;
      end else begin
         hot_r      <= hot_nxt;
         hold_cnt_r <= hold_nxt;
      end
   end

   // ---------------------------------------------------------------
   // supply level state machine
   // ---------------------------------------------------------------
   pdpm_sup_t   sup_r;
   pdpm_sup_t   sup_nxt;
   logic [31:0] start_cnt_r;
   logic [31:0] dg_cnt_r;
   logic [31:0] rise_cnt_r;
   logic [1:0]  tgt_prev_r;
   logic        attach_seen_r;
   wire  [1:0]  sup_tgt  = supply_below3_i ? 2'd3 : supply_below2_i ? 2'd2 :
                           supply_below1_i ? 2'd1 : 2'd0;
   wire  [1:0]  sup_lvl  = (sup_r == SUP_LOW1) ? 2'd1 : (sup_r == SUP_LOW2) ? 2'd2 : 2'd0;
   wire         sup_live = (sup_r == SUP_NORM) || (sup_r == SUP_LOW1) || (sup_r == SUP_LOW2);
   wire  [31:0] degl_cyc = 32'(degl_r) * DEGL_UNIT;
   wire         dg_run   = sup_live && (sup_tgt > sup_lvl) && (sup_tgt == tgt_prev_r);
   wire         dg_done  = dg_run && (dg_cnt_r + 32'd1 >= degl_cyc);
   wire         rise_run = sup_live && (sup_lvl != 2'd0) && supply_above_rise_i;
   wire         rise_end = rise_run && (rise_cnt_r >= RISE_CYC - 32'd1);
   wire         start_ok = (start_cnt_r >= START_CYC - 32'd1);

   // deeper levels jump straight in; recovery always returns to normal
   always_comb begin
      sup_nxt = sup_r;
      case (sup_r)
         SUP_WAIT: begin
            if (start_ok && (attach_seen_r || attach_i)) sup_nxt = SUP_NORM; // [R10] [R16]
         end
         SUP_NORM, SUP_LOW1, SUP_LOW2: begin
            if (dg_done) begin
               case (sup_tgt)
                  2'd3:    sup_nxt = SUP_OFF;  // [R14]
                  2'd2:    sup_nxt = SUP_LOW2; // [R12]
                  default: sup_nxt = SUP_LOW1; // [R11]
               endcase
            end else if (rise_end) begin
               sup_nxt = SUP_NORM; // [R15]
            end
         end
         default: sup_nxt = SUP_OFF;
      endcase
   end

   wire resend_nxt = contract_i && (sup_nxt != sup_r)
                     && (sup_nxt == SUP_LOW1 || sup_nxt == SUP_LOW2); // [R13]

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sup_r         <= SUP_WAIT; // [R16]
         start_cnt_r   <= 32'd0;
         dg_cnt_r      <= 32'd0;
         rise_cnt_r    <= 32'd0;
         tgt_prev_r    <= 2'd0;
         attach_seen_r <= 1'b0;
      end else begin
         sup_r         <= sup_nxt;
         start_cnt_r   <= start_ok ? start_cnt_r : start_cnt_r + 32'd1;
         dg_cnt_r      <= (dg_run && !dg_done) ? dg_cnt_r + 32'd1 : 32'd0;
         rise_cnt_r    <= (rise_run && !rise_end) ? rise_cnt_r + 32'd1 : 32'd0;
         tgt_prev_r    <= sup_tgt;
         attach_seen_r <= attach_seen_r || attach_i;
      end
   end

   // ---------------------------------------------------------------
   // rating arbitration
   // ---------------------------------------------------------------
   wire [7:0]  share_pdp = (lim_r[1][7:0] < `PDPM_PDP_FLOOR) ? `PDPM_PDP_FLOOR : lim_r[1][7:0]; // [R22]
   wire        hot2_on   = (hot_r == 2'd2) || (t1_trip_r && resp_sel); // [R2] [R8]
   wire [15:0] arb0      = lim_r[0];
   wire [15:0] arb1      = pick_min(arb0, share_act_r, {lim_r[1][15:8], share_pdp}); // [R19]
   wire [15:0] arb2      = pick_min(arb1, sup_r == SUP_LOW1, lim_r[2]);              // [R11]
   wire [15:0] arb3      = pick_min(arb2, sup_r == SUP_LOW2, lim_r[3]);              // [R12]
   wire [15:0] arb4      = pick_min(arb3, hot_r == 2'd1, lim_r[4]);                  // [R7]
   wire [15:0] arb_fin   = pick_min(arb4, hot2_on, lim_r[5]);                        // [R2]
   wire        shut_nxt  = (t1_trip_r && !resp_sel) || (sup_r == SUP_OFF);           // [R1] [R14]
   wire        lowc_nxt  = share_act_r && (arb_fin[7:0] < `PDPM_PDP_LOWCUR);         // [R22]

   // mask bit 0 is the 5 V fixed column, always on; the rest follow the mask byte
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         power_limit_o      <= 8'h00;
         profile_mask_o     <= 9'h001;
         low_current_adv_o  <= 1'b0;
         shutdown_o         <= 1'b0;
         resend_caps_o      <= 1'b0;
         supply_low1_flag_o <= 1'b0;
         supply_low2_flag_o <= 1'b0;
         profile_current_o  <= 12'h000;
      end else begin
         power_limit_o      <= arb_fin[7:0];
         profile_mask_o     <= {arb_fin[15:8], 1'b1}; // [R22] [R25]
         low_current_adv_o  <= lowc_nxt;
         shutdown_o         <= shut_nxt;
         resend_caps_o      <= resend_nxt;
         supply_low1_flag_o <= (sup_r == SUP_LOW1); // [R11]
         supply_low2_flag_o <= (sup_r == SUP_LOW2); // [R12]
         profile_current_o  <= calc_cur(power_limit_o, profile_sel_i); // [R20] [R21]
      end
   end

   assign status_w = {21'd0, 3'(sup_r), shutdown_o, share_act_r, t2_trip_r, t1_trip_r,
                      second_temp_warning_i, first_temp_warning_i, supply_low2_flag_o, supply_low1_flag_o};

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   chk_therm_shutdown: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R1]
      (t1_trip_r && !resp_sel) |=> shutdown_o) else $error("thermistor trip did not shut down");
   chk_therm_hot2: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R2]
      (t1_trip_r && resp_sel) |=> (power_limit_o <= $past(lim_r[5][7:0])))
      else $error("thermistor derate above hot level two limit");
   chk_therm_recover: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R3]
      (t1_trip_r && !therm1_below_i && (hyst_sel ? therm1_rec_b_i : therm1_rec_a_i)) |=> !t1_trip_r)
      else $error("thermistor did not recover at once");
   chk_share_req: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R17]
      ((pin1_mode == PIN1_SHARE) && !share_request_input_n_i) |=> share_act_r ##1 low_current_adv_o
      == (power_limit_o < `PDPM_PDP_LOWCUR)) else $error("share request not honoured");
   chk_share_floor: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R22]
      (share_act_r && $stable(share_act_r) && lim_r[0][7:0] >= `PDPM_PDP_FLOOR && lim_r[2][7:0] >= `PDPM_PDP_FLOOR
       && lim_r[3][7:0] >= `PDPM_PDP_FLOOR && lim_r[4][7:0] >= `PDPM_PDP_FLOOR && lim_r[5][7:0] >= `PDPM_PDP_FLOOR)
      |=> power_limit_o >= `PDPM_PDP_FLOOR) else $error("shared rating below floor");
   chk_hot_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R9]
      (hot_now < hot_r && !hold_end) |=> $stable(hot_r)) else $error("hot level released early");
   chk_start_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R10]
      (sup_r == SUP_WAIT && !start_ok) |=> sup_r == SUP_WAIT) else $error("supply checks started early");
   chk_resend_cause: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R13]
      resend_caps_o |-> ($past(contract_i) && (sup_r == SUP_LOW1 || sup_r == SUP_LOW2) && !$stable(sup_r)))
      else $error("resend without supply derating");
   chk_supply_off: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R14]
      (sup_r == SUP_OFF) |=> shutdown_o) else $error("supply low three did not shut down");
   chk_low1_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R11]
      (sup_r == SUP_LOW1) |=> supply_low1_flag_o) else $error("low1 flag missing");

endmodule
`default_nettype wire

// [bench/pdpm_peer_model.sv]
// peer port controller model: attach indicator and bus level seen by the block
`default_nettype none
module pdpm_peer_model (
   // clock
   input  wire logic       clk_i,
   // peer port state
   input  wire logic       sink_valid_i,
   input  wire logic [7:0] vbus_dv_i,
   // lines toward the block
   output logic            attach_n_o,
   output logic            level_above_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // plain registered lines: each output follows its input one clock later
   always_ff @(posedge clk_i) begin
      attach_n_o    <= !sink_valid_i;
      level_above_o <= vbus_dv_i > 8'h70; // bus in 0.1 V steps
   end
endmodule
`default_nettype wire

// [bench/tb_pd_power_derating_manager.sv]
// self-checking bench for the power derating manager
`default_nettype none
module tb_pd_power_derating_manager import pdpm_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   // stimulus, all given a value at time zero
   logic        clk = 0, rst = 1, hsel = 0, hwr = 0, t1b = 0, t1a = 0, t1r = 0, t2b = 0;
   logic        t2a = 0, sb1 = 0, sb2 = 0, sb3 = 0, sar = 0, w1 = 0, w2 = 0, att = 0, ctr = 0, sv = 0, t2r = 0;
   logic [1:0]  htr = 0;
   logic [3:0]  psel = 0;
   logic [7:0]  vdv = 0;
   logic [31:0] ha = 0, hwd = 0, q;
   wire  logic  hrdy, hresp, lca, sd, rsc, f1, f2, shn, sla;
   wire  logic [31:0] hrd;
   wire  logic [11:0] cur;
   wire  logic [7:0]  pl;
   wire  logic [8:0]  pm;
   int          n_fail = 0, num_checks = 0;
   initial begin
      forever #2.5 clk = ~clk;
   end
   // short counts keep the run brief
   pdpm_top #(.HOLD_CYC(32'h0000_0040), .START_CYC(32'h0000_0010), .RISE_CYC(32'h0000_0010),
      .DEGL_UNIT(32'h0000_0004)) dut_u (.sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(ha),
      .htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hrdy), .hrdata_o(hrd),
      .hreadyout_o(hrdy), .hresp_o(hresp), .therm1_below_i(t1b), .therm1_rec_a_i(t1a),
      .therm1_rec_b_i(t1r), .therm2_below_i(t2b), .therm2_rec_a_i(t2a), .therm2_rec_b_i(t2r),
      .share_request_input_n_i(shn), .share_level_above_i(sla), .first_temp_warning_i(w1),
      .second_temp_warning_i(w2), .supply_below1_i(sb1), .supply_below2_i(sb2), .supply_below3_i(sb3),
      .supply_above_rise_i(sar), .attach_i(att), .contract_i(ctr), .profile_sel_i(psel),
      .profile_current_o(cur), .power_limit_o(pl), .profile_mask_o(pm), .low_current_adv_o(lca),
      .shutdown_o(sd), .resend_caps_o(rsc), .supply_low1_flag_o(f1), .supply_low2_flag_o(f2));
   pdpm_peer_model peer_u (.clk_i(clk), .sink_valid_i(sv), .vbus_dv_i(vdv), .attach_n_o(shn),
      .level_above_o(sla));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // bounded wait for hready seen high at a rising edge
   task automatic rdy();
      int n;
      n = 0;
      @(posedge clk);
      while (hrdy !== 1'b1) begin
         n++;
         if (n > 40) begin
            n_fail++;
            end_of_test();
         end
         @(posedge clk);
      end
   endtask
   // one single word transfer; read data taken at the edge ending the data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
      hsel <= 1'b1;
      ha <= {24'h00_0000, a};
      hwr <= w;
      htr <= 2'b10;
      rdy();
      htr <= 2'b00;
      hwd <= {16'h0000, d};
      rdy();
      q = hrd;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      bus(1'b0, 8'h04, 16'h0000);
      chk(q[15:0], 16'hFF78);
      bus(1'b0, 8'h40, 16'h0000);
      chk(q[15:0], 16'h0000);
      chk(16'(pm), 16'h01FF);
      chk(16'({f1, f2, sd}), 16'h0000);
   endtask
   task automatic t_therm();
      bus(1'b1, 8'h18, 16'h0528);
      bus(1'b1, 8'h00, 16'h0004);
      t1b <= 1'b1;
      tick(4);
      chk(16'(sd), 16'h0001);
      t1b <= 1'b0;
      t1a <= 1'b1;
      tick(4);
      chk(16'(sd), 16'h0000);
      bus(1'b1, 8'h00, 16'h0034);
      t1b <= 1'b1;
      tick(4);
      chk(16'(pl), 16'h0028);
      chk(16'(pm), 16'h000B);
      chk(16'(sd), 16'h0000);
      t1b <= 1'b0;
      tick(4);
      chk(16'(pl), 16'h0028);
      t1r <= 1'b1;
      tick(4);
      chk(16'(pl), 16'h0078);
   endtask
   task automatic t_share();
      bus(1'b1, 8'h08, 16'h010A);
      bus(1'b1, 8'h00, 16'h0001);
      sv <= 1'b1;
      tick(5);
      chk(16'(lca), 16'h0001);
      chk(16'(pl), 16'h000F);
      chk(16'(pm), 16'h0003);
      chk(16'(cur), 16'h0096);
      psel <= 4'd5;
      tick(3);
      chk(16'(cur), 16'h007F);
      sv <= 1'b0;
      bus(1'b1, 8'h00, 16'h001A);
      vdv <= 8'h71;
      tick(5);
      chk(16'(pl), 16'h000F);
      vdv <= 8'h70;
      t2b <= 1'b1;
      tick(5);
      chk(16'(pl), 16'h000F);
      bus(1'b1, 8'h00, 16'h003A);
      t2b <= 1'b0;
      t2a <= 1'b1;
      tick(5);
      chk(16'(pl), 16'h000F);
      t2r <= 1'b1;
      tick(5);
      chk(16'(pl), 16'h0078);
   endtask
   task automatic t_warn();
      bus(1'b1, 8'h14, 16'h0350);
      w1 <= 1'b1;
      tick(4);
      chk(16'(pl), 16'h0050);
      w2 <= 1'b1;
      tick(4);
      chk(16'(pl), 16'h0028);
      chk(16'(pm), 16'h000B);
      w1 <= 1'b0;
      w2 <= 1'b0;
      tick(30);
      chk(16'(pl === 8'h78), 16'h0000);
      tick(50);
      chk(16'(pl), 16'h0078);
      psel <= 4'd1;
      tick(3);
      chk(16'(cur), 16'h012C);
      psel <= 4'd5;
      tick(3);
      chk(16'(cur), 16'h01F4);
      psel <= 4'd8;
      tick(3);
      chk(16'(cur), 16'h011D);
   endtask
   task automatic t_supply();
      int n;
      bus(1'b1, 8'h1C, 16'h0000);
      bus(1'b1, 8'h0C, 16'h0130);
      ctr <= 1'b1;
      att <= 1'b1;
      tick(4);
      sb1 <= 1'b1;
      n = 0;
      repeat (12) begin
         @(posedge clk);
         if (rsc === 1'b1) n++;
      end
      chk(16'(n), 16'h0001);
      chk(16'({f1, pl}), 16'h0130);
      bus(1'b1, 8'h10, 16'h0120);
      sb2 <= 1'b1;
      tick(8);
      chk(16'({f2, pl}), 16'h0120);
      sb1 <= 1'b0;
      sb2 <= 1'b0;
      sar <= 1'b1;
      tick(8);
      chk(16'(f2), 16'h0001);
      tick(16);
      chk(16'({f2, pl}), 16'h0078);
      {sar, sb1, sb2, sb3} <= 4'h7;
      tick(8);
      chk(16'(sd), 16'h0001);
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(2);
      chk(16'({sd, f1, f2}), 16'h0000);
      bus(1'b0, 8'h20, 16'h0000);
      chk(16'(q[10:8]), 16'h0000);
      tick(60);
      bus(1'b0, 8'h20, 16'h0000);
      chk(16'(q[10:7]), 16'h000D);
   endtask
   initial begin
      tick(3);
      rst <= 1'b0;
      tick(1);
      t_reset();
      t_therm();
      t_share();
      t_warn();
      t_supply();
      end_of_test();
   end
endmodule
`default_nettype wire
